// *** core/mfb_device.sv ***
// Motor feedback register bank: the device end of the register link.
module mfb_device (
   input wire logic clk_i,
   input wire logic rst_i,
   mfb_link_if.device link,
   input wire logic [15:0] rotation_rate_value_i,
   input wire logic [15:0] electrical_period_value_i,
   input wire logic [15:0] measured_emf_constant_i,
   input wire logic [10:0] peak_current_code_i,
   input wire logic [7:0] rotor_position_estimate_i,
   input wire logic [7:0] supply_level_code_i,
   input wire logic [7:0] active_speed_request_i,
   input wire logic [8:0] buffered_speed_request_i,
   input wire logic [5:0] fault_flags_i,
   output logic output_frequency_select_o,
   output logic [15:0] phase_resistance_o,
   output logic closed_loop_adjust_mode_o,
   output logic [15:0] back_emf_constant_o
);
   logic [7:0] param_one;
   logic [7:0] param_two;
   // The four paired feedback values, in the order of their register pairs.
   localparam int PAIRS = 4;
   logic [15:0] pair_value [PAIRS];
   logic [7:0] pair_hi_addr [PAIRS];
   logic [7:0] lo_hold [PAIRS];
   logic [3:0] res_significand;
   logic [2:0] res_shift;
   logic [3:0] emf_significand;
   logic [2:0] emf_shift;
   logic [7:0] next_rdata;
   logic rd;
   logic wr;

   // A request acts only in its first cycle; the request still held during ack is ignored.
   assign rd = link.req && !link.ack && !link.we;
   assign wr = link.req && !link.ack && link.we;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.ack <= 1'b0;
      end else begin
         link.ack <= link.req && !link.ack;
      end
   end

   // Parameter registers accept writes; every other address ignores them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         param_one <= mfb_pkg::PARAM_ONE_RESET;
      end else if (wr && link.addr == mfb_pkg::ADDR_PARAM_ONE) begin
         param_one <= link.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         param_two <= mfb_pkg::PARAM_TWO_RESET;
      end else if (wr && link.addr == mfb_pkg::ADDR_PARAM_TWO) begin
         param_two <= link.wdata;
      end
   end

   assign pair_value[0] = rotation_rate_value_i;
   assign pair_value[1] = electrical_period_value_i;
   assign pair_value[2] = measured_emf_constant_i;
   assign pair_value[3] = {5'h00, peak_current_code_i};
   assign pair_hi_addr[0] = mfb_pkg::ADDR_RATE_HI;
   assign pair_hi_addr[1] = mfb_pkg::ADDR_PERIOD_HI;
   assign pair_hi_addr[2] = mfb_pkg::ADDR_EMF_HI;
   assign pair_hi_addr[3] = mfb_pkg::ADDR_CURR_HI;

   // Low bytes are frozen at the high-byte read so a live value cannot tear the pair.
   // A low read with no high read of its pair since reset returns zero; otherwise it returns what the last high read froze.
   for (genvar g = 0; g < PAIRS; g++) begin : g_pair
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            lo_hold[g] <= 8'h00;
         end else if (rd && link.addr == pair_hi_addr[g]) begin
            lo_hold[g] <= pair_value[g][7:0];
         end
      end
   end

   // Unmapped addresses, the gaps at 0x1D and 0x1F among them, read as zero.
   always_comb begin
      next_rdata = 8'h00;
      unique case (link.addr)
         mfb_pkg::ADDR_RATE_HI: begin
            next_rdata = pair_value[0][15:8];
         end
         mfb_pkg::ADDR_RATE_LO: begin
            next_rdata = lo_hold[0];
         end
         mfb_pkg::ADDR_PERIOD_HI: begin
            next_rdata = pair_value[1][15:8];
         end
         mfb_pkg::ADDR_PERIOD_LO: begin
            next_rdata = lo_hold[1];
         end
         mfb_pkg::ADDR_EMF_HI: begin
            next_rdata = pair_value[2][15:8];
         end
         mfb_pkg::ADDR_EMF_LO: begin
            next_rdata = lo_hold[2];
         end
         mfb_pkg::ADDR_CURR_HI: begin
            next_rdata = pair_value[3][15:8];
         end
         mfb_pkg::ADDR_CURR_LO: begin
            next_rdata = lo_hold[3];
         end
         mfb_pkg::ADDR_POSITION: begin
            next_rdata = rotor_position_estimate_i;
         end
         mfb_pkg::ADDR_SUPPLY: begin
            next_rdata = supply_level_code_i;
         end
         mfb_pkg::ADDR_SPEED_ACTIVE: begin
            next_rdata = active_speed_request_i;
         end
         mfb_pkg::ADDR_SPEED_BUFFERED: begin
            next_rdata = buffered_speed_request_i[8:1];
         end
         mfb_pkg::ADDR_FAULT: begin
            next_rdata = {2'h0, fault_flags_i};
         end
         mfb_pkg::ADDR_PARAM_ONE: begin
            next_rdata = param_one;
         end
         mfb_pkg::ADDR_PARAM_TWO: begin
            next_rdata = param_two;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Read data moves only on reads, so a write leaves the last answer in place.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.rdata <= 8'h00;
      end else if (rd) begin
         link.rdata <= next_rdata;
      end
   end

   // Field decode for the two parameter registers; the motor logic sees only the results.
   assign res_significand = param_one[mfb_pkg::SIG_MSB:0];
   assign res_shift = param_one[mfb_pkg::SHIFT_MSB:mfb_pkg::SHIFT_LSB];
   assign emf_significand = param_two[mfb_pkg::SIG_MSB:0];
   assign emf_shift = param_two[mfb_pkg::SHIFT_MSB:mfb_pkg::SHIFT_LSB];

   // Decoded configuration drives the motor logic directly from flip-flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_frequency_select_o <= 1'b0;
      end else begin
         output_frequency_select_o <= param_one[mfb_pkg::FREQ_SEL_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         closed_loop_adjust_mode_o <= 1'b0;
      end else begin
         closed_loop_adjust_mode_o <= param_two[mfb_pkg::ADJ_MODE_BIT];
      end
   end

   // Four significand bits shifted by at most seven fit in sixteen bits, so nothing is lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_resistance_o <= 16'h0000;
      end else begin
         phase_resistance_o <= {12'h000, res_significand} << res_shift;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         back_emf_constant_o <= 16'h0000;
      end else begin
         back_emf_constant_o <= {12'h000, emf_significand} << emf_shift;
      end
   end
endmodule

// *** core/mfb_pkg.sv ***
// Shared register map, field positions and bus constants for the motor feedback register bank.
package mfb_pkg;
   localparam logic [7:0] ADDR_RATE_HI = 8'h11;
   localparam logic [7:0] ADDR_RATE_LO = 8'h12;
   localparam logic [7:0] ADDR_PERIOD_HI = 8'h13;
   localparam logic [7:0] ADDR_PERIOD_LO = 8'h14;
   localparam logic [7:0] ADDR_EMF_HI = 8'h15;
   localparam logic [7:0] ADDR_EMF_LO = 8'h16;
   localparam logic [7:0] ADDR_CURR_HI = 8'h17;
   localparam logic [7:0] ADDR_CURR_LO = 8'h18;
   localparam logic [7:0] ADDR_POSITION = 8'h19;
   localparam logic [7:0] ADDR_SUPPLY = 8'h1A;
   localparam logic [7:0] ADDR_SPEED_ACTIVE = 8'h1B;
   localparam logic [7:0] ADDR_SPEED_BUFFERED = 8'h1C;
   localparam logic [7:0] ADDR_FAULT = 8'h1E;
   localparam logic [7:0] ADDR_PARAM_ONE = 8'h20;
   localparam logic [7:0] ADDR_PARAM_TWO = 8'h21;
   localparam logic [7:0] PARAM_ONE_RESET = 8'h00;
   localparam logic [7:0] PARAM_TWO_RESET = 8'h00;
   // Field positions inside the parameter registers, and widths of the fault and current-high feedback fields.
   localparam int FREQ_SEL_BIT = 7;
   localparam int ADJ_MODE_BIT = 7;
   localparam int SHIFT_MSB = 6;
   localparam int SHIFT_LSB = 4;
   localparam int SIG_MSB = 3;
   localparam int FAULT_WIDTH = 6;
   localparam int CURR_HI_WIDTH = 3;
   // Controller Wishbone register offsets (byte addresses) and bit positions inside them.
   localparam logic [3:0] WB_CTRL = 4'h0;
   localparam logic [3:0] WB_DATA = 4'h4;
   localparam logic [3:0] WB_STATUS = 4'h8;
   localparam logic [3:0] WB_IRQ_STATUS = 4'hC;
   localparam logic [4:0] WB_IRQ_MASK = 5'h10;
   localparam int CTRL_START_BIT = 8;
   localparam int CTRL_WRITE_BIT = 9;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
endpackage

// *** core/mfb_link_if.sv ***
// Register access link between the host controller and the feedback register bank.
interface mfb_link_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
   modport device (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// *** core/mfb_host.sv ***
// Host controller: Wishbone slave registers that issue single register accesses on the link.
module mfb_host (
   input wire logic clk_i,
   input wire logic rst_i,
   mfb_link_if.host link,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o
);
   logic busy;
   logic [7:0] rdata;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic done_evt;
   logic acc;
   logic wr_ctrl;

   assign acc = cyc_i && stb_i && !ack_o;
   assign wr_ctrl = acc && we_i && sel_i[1] && adr_i == 5'(mfb_pkg::WB_CTRL)
      && dat_i[mfb_pkg::CTRL_START_BIT] && !busy;
   assign done_evt = link.req && link.ack;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= acc;
      end
   end

   // The host does not enforce the high-before-low order; software must keep it, issuing accesses one at a time.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         link.req <= 1'b0;
         link.we <= 1'b0;
         link.addr <= 8'h00;
         link.wdata <= 8'h00;
      end else if (wr_ctrl) begin
         busy <= 1'b1;
         link.req <= 1'b1;
         link.we <= dat_i[mfb_pkg::CTRL_WRITE_BIT];
         link.addr <= dat_i[7:0];
         link.wdata <= dat_i[23:16];
      end else if (done_evt) begin
         busy <= 1'b0;
         link.req <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata <= 8'h00;
      end else if (done_evt && !link.we) begin
         rdata <= link.rdata;
      end
   end

   // Set beats a simultaneous write-one clear so no completion is lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= 2'h0;
      end else begin
         if (acc && we_i && sel_i[0] && adr_i == 5'(mfb_pkg::WB_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~dat_i[1:0]) | {1'b0, done_evt};
         end else begin
            irq_status <= irq_status | {1'b0, done_evt};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= 2'h0;
      end else if (acc && we_i && sel_i[0] && adr_i == mfb_pkg::WB_IRQ_MASK) begin
         irq_mask <= dat_i[1:0];
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (acc && !we_i) begin
         unique case (adr_i)
            5'(mfb_pkg::WB_CTRL): dat_o <= {22'h0, link.we, busy, link.addr};
            5'(mfb_pkg::WB_DATA): dat_o <= {24'h0, rdata};
            5'(mfb_pkg::WB_STATUS): dat_o <= {31'h0, busy};
            5'(mfb_pkg::WB_IRQ_STATUS): dat_o <= {30'h0, irq_status};
            mfb_pkg::WB_IRQ_MASK: dat_o <= {30'h0, irq_mask};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// *** test/mfb_link_assertions.sv ***
// Concurrent checks on the register link between host controller and register bank.
module mfb_link_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_ask;
      req && !ack;
   endsequence
   sequence s_done;
      ack ##1 (!ack && !req);
   endsequence
   // Addresses with no register behind them must read back as zero.
   logic hole;
   assign hole = addr < 8'h11 || addr > 8'h21 || addr == 8'h1D || addr == 8'h1F;
   chk_answer_next: assert property (s_ask |=> s_done)
      else $error("link request not answered in the next cycle");
   chk_ack_single: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   chk_ack_cause: assert property (ack |-> $past(req && !ack))
      else $error("link ack without a request");
   chk_idle_quiet: assert property (!req |=> !ack)
      else $error("link ack while idle");
   chk_req_steady: assert property (
      s_ask |=> $stable(addr) && $stable(we) && $stable(wdata))
      else $error("link request changed before ack");
   chk_hole_zero: assert property (ack && !we && hole |-> rdata == 8'h00)
      else $error("unmapped link read not zero");
   chk_curr_pad: assert property (
      ack && !we && addr == mfb_pkg::ADDR_CURR_HI |-> rdata[7:3] == 5'h00)
      else $error("peak current high byte unused bits set");
   chk_fault_pad: assert property (
      ack && !we && addr == mfb_pkg::ADDR_FAULT |-> rdata[7:6] == 2'h0)
      else $error("fault byte unused bits set");
endmodule

// *** test/tb_motor_feedback_register_bank.sv ***
// Self-checking bench for the register bank and its host controller joined by the link.
`define CHK(what, exp, got) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
   end \
end
module tb_motor_feedback_register_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o, rd;
   logic ack_o, irq_o, fsel, adj;
   logic [15:0] rate = 16'h01FF, period = 16'h1234, emf = 16'hA55A, res, kt;
   logic [10:0] curr = 11'h43C;
   logic [8:0] bspd = 9'h1FE;
   logic [5:0] flt = 6'h2A;
   logic [7:0] b, pv;
   logic [15:0] vals [4] = '{16'h01FF, 16'h1234, 16'hA55A, 16'h043C};
   logic [7:0] sa [6] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E, 8'h1D};
   logic [7:0] se [6] = '{8'h5A, 8'h67, 8'hFF, 8'hFF, 8'h2A, 8'h00};
   logic [7:0] pw [4] = '{8'hB5, 8'h7F, 8'h12, 8'h83};
   int n_errors = 0;
   int check_count = 0;
   always #12.5 clk_i = ~clk_i;
   mfb_link_if i_mfb_link_if ();
   mfb_host i_mfb_host (.clk_i(clk_i), .rst_i(rst_i), .link(i_mfb_link_if), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o));
   mfb_device i_mfb_device (.clk_i(clk_i), .rst_i(rst_i), .link(i_mfb_link_if),
      .rotation_rate_value_i(rate), .electrical_period_value_i(period),
      .measured_emf_constant_i(emf), .peak_current_code_i(curr),
      .rotor_position_estimate_i(8'h5A), .supply_level_code_i(8'h67),
      .active_speed_request_i(8'hFF), .buffered_speed_request_i(bspd), .fault_flags_i(flt),
      .output_frequency_select_o(fsel), .phase_resistance_o(res),
      .closed_loop_adjust_mode_o(adj), .back_emf_constant_o(kt));
   mfb_link_assertions i_mfb_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
      .req(i_mfb_link_if.req), .we(i_mfb_link_if.we), .addr(i_mfb_link_if.addr),
      .wdata(i_mfb_link_if.wdata), .ack(i_mfb_link_if.ack), .rdata(i_mfb_link_if.rdata));
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Issues one link access through the controller and waits until it is no longer busy.
   task automatic link(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      n = 0;
      wb(1'b1, 5'(mfb_pkg::WB_CTRL), {8'h00, d, 6'h00, w, 1'b1, a}, rd);
      do begin
         wb(1'b0, 5'(mfb_pkg::WB_STATUS), 32'h0, rd);
         n++;
      end while (rd[0] !== 1'b0 && n < 20);
      if (n >= 20) n_errors++;
      wb(1'b0, 5'(mfb_pkg::WB_DATA), 32'h0, rd);
      q = rd[7:0];
   endtask
   task automatic set_fb(input logic [15:0] m);
      rate <= vals[0] ^ m;
      period <= vals[1] ^ m;
      emf <= vals[2] ^ m;
      curr <= vals[3][10:0] ^ m[10:0];
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      link(1'b0, mfb_pkg::ADDR_PARAM_ONE, 8'h00, b);
      `CHK("param one reset", mfb_pkg::PARAM_ONE_RESET, b)
      link(1'b0, mfb_pkg::ADDR_PARAM_TWO, 8'h00, b);
      `CHK("param two reset", mfb_pkg::PARAM_TWO_RESET, b)
      // The inputs flip between the two reads, so only a latched low byte matches.
      for (int i = 0; i < 4; i++) begin
         link(1'b0, 8'h11 + 8'(i * 2), 8'h00, b);
         `CHK("high byte", vals[i][15:8], b)
         set_fb(16'hFFFF);
         link(1'b0, 8'h12 + 8'(i * 2), 8'h00, b);
         `CHK("latched low byte", vals[i][7:0], b)
         set_fb(16'h0000);
      end
      $display("test paired reads done");
      for (int i = 0; i < 6; i++) begin
         link(1'b0, sa[i], 8'h00, b);
         `CHK("single byte", se[i], b)
      end
      link(1'b1, mfb_pkg::ADDR_RATE_HI, 8'h77, b);
      link(1'b0, mfb_pkg::ADDR_RATE_HI, 8'h00, b);
      `CHK("read-only rate", 8'h01, b)
      $display("test feedback bytes done");
      for (int i = 0; i < 4; i++) begin
         pv = pw[i];
         link(1'b1, 8'h20 + 8'(i % 2), pv, b);
         link(1'b0, 8'h20 + 8'(i % 2), 8'h00, b);
         `CHK("param readback", pv, b)
         if (i % 2 == 0) begin
            `CHK("frequency select", pv[7], fsel)
            `CHK("phase resistance", 16'(pv[3:0]) << pv[6:4], res)
         end else begin
            `CHK("adjust mode", pv[7], adj)
            `CHK("emf constant", 16'(pv[3:0]) << pv[6:4], kt)
         end
      end
      $display("test parameters done");
      wb(1'b1, 5'(mfb_pkg::WB_IRQ_MASK), 32'h0, rd);
      wb(1'b1, 5'(mfb_pkg::WB_IRQ_STATUS), 32'h1, rd);
      link(1'b0, mfb_pkg::ADDR_SUPPLY, 8'h00, b);
      wb(1'b0, 5'(mfb_pkg::WB_IRQ_STATUS), 32'h0, rd);
      `CHK("done status", 1'b1, rd[0])
      `CHK("masked irq", 1'b0, irq_o)
      wb(1'b1, 5'(mfb_pkg::WB_IRQ_MASK), 32'h1, rd);
      `CHK("unmasked irq", 1'b1, irq_o)
      wb(1'b1, 5'(mfb_pkg::WB_IRQ_STATUS), 32'h1, rd);
      `CHK("cleared irq", 1'b0, irq_o)
      $display("test interrupt done");
      // A short reset in mid-run must bring parameter two and the adjust mode back to their reset values.
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      link(1'b0, mfb_pkg::ADDR_PARAM_TWO, 8'h00, b);
      `CHK("param two after reset", mfb_pkg::PARAM_TWO_RESET, b)
      `CHK("adjust mode after reset", mfb_pkg::PARAM_TWO_RESET[mfb_pkg::ADJ_MODE_BIT], adj)
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
